// ---- design/ebrw_ctrl.v ----
// Ready-controlled wait-state sequencer for external bus cycles
//
// Functional notes
// - An external circuit can stretch every bus cycle started with READY_EN_I set through ready until ready is seen active.
// - A polarity input selects whether a high or a low ready level counts as active.
// - In asynchronous mode ready passes one extra stage, costing at least one more wait state.
// - At each sample point inactive ready adds a wait state and active ready ends the cycle.
// - Sample points fall on every phase tick in both modes and come only after the programmed access phase.
// - Read data is captured on the same edge that raises the read strobe.
//
// Cycle outline
// A cycle opens on the edge that takes START_I while the sequencer is idle.
// The strobe of the chosen direction falls on that edge and stays low until the cycle ends.
// The access phase then runs for the programmed number of phase ticks, clamped to range.
// Ready is ignored throughout the access phase.
// A ready-controlled cycle then waits in the ready state, looking at ready once per tick.
// Each tick with inactive ready is one ready wait phase; a tick with active ready ends it.
//
// Timing notes
// Ready and read data arrive from pins and pass two flops before any logic reads them.
// Asynchronous mode adds a third flop and holds off one more tick after ready is seen.
// That way such a cycle always costs at least one wait phase more than a synchronous one.
// The synchronous path skips the extra flop; the external circuit must then move ready
// in step with the reference clock, otherwise a sample may catch a changing level.
// Read data are taken from the second data flop on the edge that raises the read strobe,
// so the external circuit may change them right after that edge.
//
// Limitations
// The ready level is looked at on phase ticks only; a pulse shorter than one reference half
// period plus setup can be missed entirely in either mode.
// Configuration is latched when a cycle starts; changes during a cycle wait for the next.
// START_I during a running cycle is ignored, not queued.
// The data pins are synchronised bit by bit, so they must be stable well before the end.
`timescale 1ns/100ps
`include "ebrw_defs.vh"
module ebrw_ctrl #(
   parameter DATA_W = 16,
   parameter REF_DIV = `EBRW_REF_DIV
) (
   // Clock and reset
   input wire CLK_I,
   input wire NRST_I,
   // Cycle request from the bus controller
   input wire START_I,
   input wire WRITE_I,
   input wire READY_EN_I,
   input wire READY_ASYNC_I,
   input wire READY_POL_I,
   input wire [`EBRW_ACC_W-1:0] ACCESS_PHASE_LEN_I,
   // External pins
   input wire READY_I,
   input wire [DATA_W-1:0] DATA_I,
   output wire REF_CLOCK_OUTPUT_O,
   output wire RD_N_O,
   output wire WR_N_O,
   // Status towards the bus controller
   output wire BUSY_O,
   output wire DONE_O,
   output wire READY_WAIT_PHASE_O,
   output wire [DATA_W-1:0] RDATA_O
);
   reg [1:0] rst_sync_ff;
   wire rst_n = rst_sync_ff[1];
   reg [1:0] state_ff, nxt_state;
   reg [`EBRW_ACC_W-1:0] cnt_ff, nxt_cnt;
   reg [7:0] div_ff;
   reg ref_ff;
   reg rd_sync1_ff, rd_sync2_ff, rd_async_ff;
   reg write_ff, async_ff, pol_ff, ren_ff;
   reg hit_ff, nxt_hit;
   reg rd_n_ff, wr_n_ff, done_ff;
   reg [DATA_W-1:0] d_sync1_ff, d_sync2_ff, rdata_ff;
   wire tick;
   wire rdy_pin_act;
   wire rdy_seen;

   // Clamp limits at counter width so the phase load never drops bits
   localparam [`EBRW_ACC_W-1:0] ACC_LO = `EBRW_ACC_MIN;
   localparam [`EBRW_ACC_W-1:0] ACC_HI = `EBRW_ACC_MAX;

   // Reset release through two stages
   always @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I)
         rst_sync_ff <= 2'h0;
      else
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end

   // Reference clock divider; one phase equals one reference half period enable
   assign tick = (div_ff == REF_DIV - 1);
   always @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         div_ff <= 8'h00;
         ref_ff <= 1'b0;
      end else if (tick) begin
         div_ff <= 8'h00;
         ref_ff <= ~ref_ff;
      end else begin
         div_ff <= div_ff + 8'h01;
      end
   end

   // Pin inputs pass two flops; the async path adds one more stage
   always @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         rd_sync1_ff <= 1'b0;
         rd_sync2_ff <= 1'b0;
         rd_async_ff <= 1'b0;
         d_sync1_ff <= {DATA_W{1'b0}};
         d_sync2_ff <= {DATA_W{1'b0}};
      end else begin
         rd_sync1_ff <= READY_I;
         rd_sync2_ff <= rd_sync1_ff;
         rd_async_ff <= rd_sync2_ff;
         d_sync1_ff <= DATA_I;
         d_sync2_ff <= d_sync1_ff;
      end
   end

   // Polarity and mode select; async mode looks one stage later
   assign rdy_pin_act = (async_ff ? rd_async_ff : rd_sync2_ff) ~^ pol_ff;
   assign rdy_seen = rdy_pin_act;

   // Cycle sequencer
   always @* begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_hit = hit_ff;
      case (state_ff)
         `EBRW_ST_IDLE: begin
            if (START_I) begin
               nxt_state = `EBRW_ST_ACCESS;
               nxt_hit = 1'b0;
               nxt_cnt = (ACCESS_PHASE_LEN_I < ACC_LO) ? ACC_LO :
                         (ACCESS_PHASE_LEN_I > ACC_HI) ? ACC_HI :
                         ACCESS_PHASE_LEN_I;
            end
         end
         `EBRW_ST_ACCESS: begin
            // Ready is ignored until the access phase has elapsed
            if (tick) begin
               if (cnt_ff > ACC_LO)
                  nxt_cnt = cnt_ff - 1'b1;
               else if (ren_ff)
                  nxt_state = `EBRW_ST_READY;
               else
                  nxt_state = `EBRW_ST_END;
            end
         end
         `EBRW_ST_READY: begin
            // Sample point on every phase: inactive waits, active terminates
            // Async mode spends one more phase after ready is seen
            if (tick && (rdy_seen || hit_ff)) begin
               if (async_ff && !hit_ff)
                  nxt_hit = 1'b1;
               else
                  nxt_state = `EBRW_ST_END;
            end
         end
         `EBRW_ST_END: begin
            nxt_state = `EBRW_ST_IDLE;
         end
         default: begin
            nxt_state = `EBRW_ST_IDLE;
         end
      endcase
   end

   // State, strobes and captured configuration
   always @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= `EBRW_ST_IDLE;
         cnt_ff <= {`EBRW_ACC_W{1'b0}};
         hit_ff <= 1'b0;
         write_ff <= 1'b0;
         async_ff <= 1'b0;
         pol_ff <= 1'b1;
         ren_ff <= 1'b0;
         rd_n_ff <= 1'b1;
         wr_n_ff <= 1'b1;
         done_ff <= 1'b0;
         rdata_ff <= {DATA_W{1'b0}};
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         hit_ff <= nxt_hit;
         done_ff <= 1'b0;
         if (state_ff == `EBRW_ST_IDLE && START_I) begin
            // Mode latched per cycle so a change mid-cycle cannot glitch sampling
            write_ff <= WRITE_I;
            async_ff <= READY_ASYNC_I;
            pol_ff <= READY_POL_I;
            ren_ff <= READY_EN_I;
            rd_n_ff <= WRITE_I;
            wr_n_ff <= ~WRITE_I;
         end
         if (nxt_state == `EBRW_ST_END && state_ff != `EBRW_ST_END) begin
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
            done_ff <= 1'b1;
            if (!write_ff)
               rdata_ff <= d_sync2_ff;
         end
      end
   end

   // Outputs come straight from flops, apart from the two state decodes
   assign REF_CLOCK_OUTPUT_O = ref_ff;
   assign RD_N_O = rd_n_ff;
   assign WR_N_O = wr_n_ff;
   assign BUSY_O = (state_ff != `EBRW_ST_IDLE);
   assign DONE_O = done_ff;
   assign READY_WAIT_PHASE_O = (state_ff == `EBRW_ST_READY);
   assign RDATA_O = rdata_ff;
endmodule

// ---- design/ebrw_defs.vh ----
// Constants for the external bus ready and wait-state control block
`ifndef EBRW_DEFS_VH
`define EBRW_DEFS_VH
`define EBRW_CLK_PERIOD_NS 10
`define EBRW_REF_DIV 2
`define EBRW_ACC_MIN 1
`define EBRW_ACC_MAX 32
`define EBRW_ACC_W 6
`define EBRW_ST_IDLE 2'h0
`define EBRW_ST_ACCESS 2'h1
`define EBRW_ST_READY 2'h2
`define EBRW_ST_END 2'h3
`endif

// ---- verif/ebrw_ctrl_sva.sv ----
// Property checker for the ready wait-state sequencer
`timescale 1ns/100ps
module ebrw_ctrl_sva #(parameter DATA_W = 16) (
   input wire CLK_I, input wire NRST_I, input wire START_I, input wire WRITE_I,
   input wire READY_EN_I, input wire READY_ASYNC_I, input wire READY_POL_I,
   input wire [5:0] ACCESS_PHASE_LEN_I, input wire READY_I, input wire [DATA_W-1:0] DATA_I,
   input wire REF_CLOCK_OUTPUT_O, input wire RD_N_O, input wire WR_N_O, input wire BUSY_O,
   input wire DONE_O, input wire READY_WAIT_PHASE_O, input wire [DATA_W-1:0] RDATA_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);
   a_done_single: assert property (DONE_O |=> !DONE_O) else $error("done too long");
   a_done_strobe: assert property (DONE_O |->
      RD_N_O && WR_N_O && $past(!(RD_N_O && WR_N_O))) else $error("done without strobe rise");
   a_wait_busy: assert property (READY_WAIT_PHASE_O |-> BUSY_O) else $error("idle wait");
   a_no_early: assert property (START_I && !BUSY_O |=> !DONE_O [*2]) else $error("early end");
   // Three register stages on the ready path, but in async mode hit_ff holds a seen ready until the next tick, past four quiet cycles
   a_inact_hold: assert property (
      (READY_WAIT_PHASE_O && READY_I != READY_POL_I) [*4] |=> !DONE_O)
      else $error("ended on inactive ready");
   a_rdata_hold: assert property (!$rose(RD_N_O) |-> $stable(RDATA_O)) else $error("rdata moved");
   a_busy_idle: assert property ($fell(BUSY_O) |-> $past(DONE_O)) else $error("lost cycle");
   c_read: cover property ($rose(RD_N_O) && DONE_O);
   c_write: cover property ($rose(WR_N_O) && DONE_O);
   c_wait: cover property (READY_WAIT_PHASE_O [*8]);
endmodule
bind ebrw_ctrl ebrw_ctrl_sva #(.DATA_W(DATA_W)) u_ebrw_ctrl_sva (.*);

// ---- verif/ebrw_ready_model.sv ----
// External circuit that ends each bus cycle with ready while hang_i is low
`timescale 1ns/100ps
module ebrw_ready_model (
   input wire ref_clk_i, input wire rd_n_i, input wire wr_n_i, input wire pol_i,
   input wire hang_i, output wire ready_o
);
   reg [1:0] cnt_ff = 2'h0;
   reg act_ff = 1'b0;
   wire idle = rd_n_i & wr_n_i;
   assign ready_o = act_ff ? pol_i : ~pol_i;
   // Moves on the reference clock only; a strobe rise drops ready at once
   always @(posedge ref_clk_i or posedge idle) begin
      if (idle) begin
         cnt_ff <= 2'h0;
         act_ff <= 1'b0;
      end else if (!hang_i) begin
         cnt_ff <= cnt_ff + 2'h1;
         if (cnt_ff == 2'h3) act_ff <= 1'b1;
      end
   end
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the ready wait-state sequencer
`timescale 1ns/100ps
module tb_top;
   reg clk = 0, nrst = 0, st = 0, wr = 0, en = 0, asy = 0, pol = 1, hang = 0;
   reg [5:0] acc = 6'h01;
   reg [15:0] din = 16'h0000, last = 16'h0000;
   reg [17:0] rows [0:3];
   wire rck, rdn, wrn, busy, done, wph, rdy;
   wire [15:0] rdat;
   integer mismatches = 0, num_checks = 0, n, i;
   ebrw_ctrl #(.REF_DIV(8)) u_ebrw_ctrl (.CLK_I(clk), .NRST_I(nrst), .START_I(st), .WRITE_I(wr),
      .READY_EN_I(en), .READY_ASYNC_I(asy), .READY_POL_I(pol), .ACCESS_PHASE_LEN_I(acc),
      .READY_I(rdy), .DATA_I(din), .REF_CLOCK_OUTPUT_O(rck), .RD_N_O(rdn), .WR_N_O(wrn),
      .BUSY_O(busy), .DONE_O(done), .READY_WAIT_PHASE_O(wph), .RDATA_O(rdat));
   ebrw_ready_model u_ebrw_ready_model (.ref_clk_i(rck), .rd_n_i(rdn), .wr_n_i(wrn),
      .pol_i(pol), .hang_i(hang), .ready_o(rdy));
   initial forever #5 clk = ~clk;
   task chk(input ok);
      begin
         num_checks = num_checks + 1;
         if (!ok) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t mismatch", $time);
         end
      end
   endtask
   // Bounded wait so a stuck cycle cannot hang the run
   task wdone;
      begin
         n = 0;
         while (done !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1 n = n + 1;
         end
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d mismatches %0d", num_checks, mismatches);
         if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   initial begin
      // Rows: least cycles to done, then write, ready on, async, polarity, access phases
      // Ready rows wait for four reference edges of the model, so at least 48 clocks
      rows[0] = 18'h0C141;
      rows[1] = 18'h0C383;
      rows[2] = 18'h02042;
      rows[3] = 18'h0C360;
      repeat (16) @(posedge clk);
      #1 chk(rdn === 1'b1 && wrn === 1'b1 && busy === 1'b0);
      $display("test reset ends");
      nrst = 1;
      repeat (3) @(posedge clk);
      for (i = 0; i < 4; i = i + 1) begin
         repeat (2) @(posedge clk);
         #1 {wr, en, asy, pol, acc} = rows[i][9:0];
         din = 16'hA500 + i;
         st = 1;
         @(posedge clk);
         #1 st = 0;
         wdone;
         if (!wr) last = din;
         chk(done === 1'b1 && n >= rows[i][17:10]);
         chk(rdat === last);
         $display("test %0d ends", i);
      end
      // Ready held back: the cycle must stay open
      repeat (2) @(posedge clk);
      #1 {wr, en, asy, pol, acc} = 10'h141;
      hang = 1;
      st = 1;
      @(posedge clk);
      #1 st = 0;
      repeat (200) @(posedge clk);
      #1 chk(wph === 1'b1 && busy === 1'b1 && rdn === 1'b0);
      hang = 0;
      wdone;
      chk(done === 1'b1);
      $display("test hold ends");
      // Reset in mid-cycle: strobes return high at once, then a fresh read still works
      repeat (2) @(posedge clk);
      #1 hang = 1;
      st = 1;
      @(posedge clk);
      #1 st = 0;
      repeat (20) @(posedge clk);
      #1 nrst = 0;
      #1 chk(rdn === 1'b1 && busy === 1'b0 && wph === 1'b0);
      repeat (4) @(posedge clk);
      #1 nrst = 1;
      hang = 0;
      repeat (3) @(posedge clk);
      #1 st = 1;
      @(posedge clk);
      #1 st = 0;
      wdone;
      chk(done === 1'b1 && rdat === din);
      $display("test midreset ends");
      finish_test;
   end
   initial begin
      #100000;
      mismatches = mismatches + 1;
      finish_test;
   end
endmodule
